// ### design/gauge_block_data_access_lock.sv
// block data access, checksum commit and lock control
`timescale 1ns/1ps
module gauge_block_data_access_lock
	import gauge_blk_pkg::*;
#(
	parameter int   AW       = 4,
	parameter int   LOCK_CYC = LOCK_CYC_DEF,
	parameter blk_t ROM_BLK  = '0
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// host byte commands
	input  wire cmd_req_t    cmd_req,
	input  wire logic [7:0]  std_rdata,
	output logic [7:0]       cmd_rdata,
	output logic             cmd_rvalid,
	// command word port
	input  wire logic        ctl_wr,
	input  wire logic [15:0] ctl_word,
	// unlock key update
	input  wire logic        key_wr,
	input  wire logic [31:0] key_wdata,
	// status
	output logic             locked_flag
);

	////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]           class_q, class_d;
	logic [7:0]           blkidx_q, blkidx_d;
	logic                 acc_q, acc_d;
	blk_t                 buf_q, buf_d;
	logic                 load_q, load_d;
	logic                 mkload_q, mkload_d;
	logic [WCNT_W-1:0]    wcnt_q, wcnt_d;
	logic                 ovf_q, ovf_d;
	logic [7:0]           rdata_q, rdata_d;
	logic                 rvalid_q, rvalid_d;
	logic [31:0]          key_q, key_d;
	blk_t                 maker_q, maker_d;
	logic                 locked, lock_set;
	logic                 commit, mk_sel, ram_sel;
	logic [7:0]           exp_sum;
	logic [WIN_IDX_W-1:0] idx;
	logic                 win_hit;
	logic [AW-1:0]        baddr;
	blk_t                 nvm_rd, ram_rd;

	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] blk_sum(input blk_t b, input logic mk);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < BLK_BYTES; i++)
			if (!mk || i < MAKER_BYTES)
				s = s + b[i];
		return s;
	endfunction : blk_sum

	function automatic logic [AW-1:0] blk_addr(input logic [7:0] c,
						   input logic [7:0] b);
		return {c[AW-2:0], b[0]};
	endfunction : blk_addr

	assign win_hit = cmd_req.addr >= WIN_BASE && cmd_req.addr <= WIN_LAST;
	assign idx     = cmd_req.addr[WIN_IDX_W-1:0];
	assign baddr   = blk_addr(class_q, blkidx_q);
	assign ram_sel = class_q[RAM_BIT];
	assign mk_sel  = locked || class_q == MAKER_CLASS;
	assign exp_sum = SUM_BASE - blk_sum(buf_q, locked);

	////////////////////////////////////////////////////////////////////
	// memories and lock control

	blk_mem #(
		.AW      (AW),
		.HAS_DEF (1'b0),
		.DEF_BLK ('0)
	) u_nvm (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wr_en   (commit && !mk_sel && !ram_sel),
		.wr_addr (baddr),
		.wr_data (buf_q),
		.rd_addr (baddr),
		.rd_data (nvm_rd)
	);

	blk_mem #(
		.AW      (AW),
		.HAS_DEF (1'b1),
		.DEF_BLK (ROM_BLK)
	) u_ram (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wr_en   (commit && !mk_sel && ram_sel),
		.wr_addr (baddr),
		.wr_data (buf_q),
		.rd_addr (baddr),
		.rd_data (ram_rd)
	);

	unlock_key_seq #(
		.LOCK_CYC (LOCK_CYC)
	) u_key (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.ctl_wr     (ctl_wr),
		.ctl_word   (ctl_word),
		.key        (key_q),
		.locked_q   (locked),
		.lock_set_q (lock_set)
	);

	////////////////////////////////////////////////////////////////////
	// host command decode

	always_comb
	begin
		class_d  = class_q;
		blkidx_d = blkidx_q;
		acc_d    = acc_q;
		buf_d    = buf_q;
		load_d   = 1'b0;
		mkload_d = 1'b0;
		wcnt_d   = wcnt_q;
		ovf_d    = ovf_q;
		maker_d  = maker_q;
		commit   = 1'b0;
		// buffer reload one cycle after selection
		if (load_q || mkload_q)
		begin
			wcnt_d = '0;
			ovf_d  = 1'b0;
			if (mkload_q || mk_sel)
				buf_d = {{(BLK_BYTES-MAKER_BYTES){RST_BYTE}},
					 maker_q[MAKER_BYTES-1:0]};
			else
				buf_d = ram_sel ? ram_rd : nvm_rd;
		end
		if (cmd_req.wr)
		begin
			if (cmd_req.addr == CLASS_ADDR && !locked)
			begin
				class_d = cmd_req.wdata;
				load_d  = acc_q;
			end
			else if (cmd_req.addr == BLKIDX_ADDR)
			begin
				blkidx_d = cmd_req.wdata;
				load_d   = acc_q && !locked;
				mkload_d = locked && cmd_req.wdata == MAKER_BLK;
			end
			else if (cmd_req.addr == ACC_ADDR && !locked)
			begin
				acc_d  = cmd_req.wdata == ACC_ENABLE;
				load_d = cmd_req.wdata == ACC_ENABLE;
			end
			else if (win_hit && !locked)
			begin
				buf_d[idx] = cmd_req.wdata;
				if (wcnt_d == WCNT_W'(BLK_BYTES))
					ovf_d = 1'b1;
				else
					wcnt_d = wcnt_d + WCNT_W'(1);
			end
			else if (cmd_req.addr == SUM_ADDR && !locked && acc_q)
			begin
				commit = cmd_req.wdata == exp_sum && !ovf_q;
				if (commit && mk_sel)
					maker_d[MAKER_BYTES-1:0] = buf_q[MAKER_BYTES-1:0];
			end
		end
		if (lock_set)
		begin
			// drop open data on entry to the locked state
			acc_d = 1'b0;
			buf_d = '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// host read answer

	always_comb
	begin
		rdata_d  = rdata_q;
		rvalid_d = cmd_req.rd;
		if (cmd_req.rd)
		begin
			if (cmd_req.addr <= STD_LAST)
				rdata_d = std_rdata;
			else if (cmd_req.addr == CLASS_ADDR)
				rdata_d = locked ? RST_BYTE : class_q;
			else if (cmd_req.addr == BLKIDX_ADDR)
				rdata_d = blkidx_q;
			else if (win_hit)
				rdata_d = buf_q[idx];
			else if (cmd_req.addr == SUM_ADDR)
				rdata_d = exp_sum;
			else if (cmd_req.addr == ACC_ADDR)
				rdata_d = (locked || acc_q) ? ACC_ENABLE : ACC_IDLE;
			else
				rdata_d = RST_BYTE;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rdata_q  <= RST_BYTE;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// unlock key register

	always_comb
	begin
		key_d = key_q;
		if (key_wr && !locked)
			key_d = key_wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			key_q <= KEY_DEFAULT;
		else
			key_q <= key_d;
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			class_q  <= RST_BYTE;
			blkidx_q <= RST_BYTE;
			acc_q    <= 1'b0;
			buf_q    <= '0;
			load_q   <= 1'b0;
			mkload_q <= 1'b0;
			wcnt_q   <= '0;
			ovf_q    <= 1'b0;
		end
		else
		begin
			class_q  <= class_d;
			blkidx_q <= blkidx_d;
			acc_q    <= acc_d;
			buf_q    <= buf_d;
			load_q   <= load_d;
			mkload_q <= mkload_d;
			wcnt_q   <= wcnt_d;
			ovf_q    <= ovf_d;
		end
	end

	// maker info is nonvolatile
	always_ff @(posedge sys_clk)
	begin
		maker_q <= maker_d;
	end

	assign cmd_rdata   = rdata_q;
	assign cmd_rvalid  = rvalid_q;
	assign locked_flag = locked;

endmodule : gauge_block_data_access_lock

// ### design/gauge_blk_pkg.sv
// shared constants and types of the block data access and lock logic
package gauge_blk_pkg;

	// command addresses
	localparam logic [7:0] STD_LAST    = 8'h3D;
	localparam logic [7:0] CLASS_ADDR  = 8'h3E;
	localparam logic [7:0] BLKIDX_ADDR = 8'h3F;
	localparam logic [7:0] WIN_BASE    = 8'h40;
	localparam logic [7:0] WIN_LAST    = 8'h5F;
	localparam logic [7:0] SUM_ADDR    = 8'h60;
	localparam logic [7:0] ACC_ADDR    = 8'h61;

	// block layout
	localparam int         BLK_BYTES   = 32;
	localparam int         WIN_IDX_W   = 5;
	localparam int         MAKER_BYTES = 8;
	localparam int         WCNT_W      = 6;
	localparam logic [7:0] SUM_BASE    = 8'hFF;

	// command values
	localparam logic [7:0]  ACC_ENABLE  = 8'h00;
	localparam logic [7:0]  ACC_IDLE    = 8'h01;
	localparam logic [7:0]  MAKER_BLK   = 8'h01;
	localparam logic [7:0]  MAKER_CLASS = 8'h39;
	localparam logic [15:0] LOCK_SUBCMD = 16'h0020;
	localparam int          RAM_BIT     = 6;

	// reset values (key value arbitrary)
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [31:0] KEY_DEFAULT = 32'h3672_0414;

	// lock delay: longest time rounds down
	localparam longint CLK_HZ      = 200_000_000;
	localparam longint LOCK_TIME_S = 2;
	localparam int     LOCK_CYC_DEF = int'(LOCK_TIME_S * CLK_HZ);

	// host byte command
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cmd_req_t;

	typedef logic [BLK_BYTES-1:0][7:0] blk_t;

	function automatic logic [15:0] swap16(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction : swap16

endpackage : gauge_blk_pkg

// ### design/blk_mem.sv
// array of 32-byte blocks, optional default load at reset
`timescale 1ns/1ps
module blk_mem
	import gauge_blk_pkg::*;
#(
	parameter int   AW       = 4,
	parameter bit   HAS_DEF  = 1'b0,
	parameter blk_t DEF_BLK  = '0
)(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire blk_t          wr_data,
	// read side
	input  wire logic [AW-1:0] rd_addr,
	output blk_t               rd_data
);

	blk_t mem [2**AW];

	assign rd_data = mem[rd_addr];

	generate
		if (HAS_DEF)
		begin : g_work
			always_ff @(posedge sys_clk)
			begin
				if (rst)
				begin
					for (int i = 0; i < 2**AW; i++)
						mem[i] <= DEF_BLK;
				end
				else if (wr_en)
					mem[wr_addr] <= wr_data;
			end
		end
		else
		begin : g_nv
			// kept across reset
			always_ff @(posedge sys_clk)
			begin
				if (wr_en)
					mem[wr_addr] <= wr_data;
			end
		end
	endgenerate

endmodule : blk_mem

// ### design/unlock_key_seq.sv
// lock subcommand timer and two-word unlock key sequence
`timescale 1ns/1ps
module unlock_key_seq
	import gauge_blk_pkg::*;
#(
	parameter int LOCK_CYC = LOCK_CYC_DEF
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// command word port
	input  wire logic        ctl_wr,
	input  wire logic [15:0] ctl_word,
	input  wire logic [31:0] key,
	// state
	output logic             locked_q,
	output logic             lock_set_q
);

	localparam int CW = $clog2(LOCK_CYC + 1);

	typedef enum logic {KS_IDLE, KS_GOT1} ks_t;

	ks_t           st_q, st_d;
	logic          pend_q, pend_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          locked_d, lock_set_d;
	logic [15:0]   k1, k0;

	assign k1 = swap16(key[15:0]);
	assign k0 = swap16(key[31:16]);

	always_comb
	begin
		st_d       = st_q;
		pend_d     = pend_q;
		cnt_d      = cnt_q;
		locked_d   = locked_q;
		lock_set_d = 1'b0;
		if (pend_q)
		begin
			if (cnt_q == CW'(LOCK_CYC - 1))
			begin
				pend_d     = 1'b0;
				locked_d   = 1'b1;
				lock_set_d = 1'b1;
			end
			else
				cnt_d = cnt_q + CW'(1);
		end
		if (ctl_wr)
		begin
			if (!locked_q)
			begin
				st_d = KS_IDLE;
				if (ctl_word == LOCK_SUBCMD && !pend_q)
				begin
					pend_d = 1'b1;
					cnt_d  = '0;
				end
			end
			else
			begin
				case (st_q)
					KS_IDLE:
						st_d = (ctl_word == k1) ? KS_GOT1 : KS_IDLE;
					KS_GOT1:
					begin
						if (ctl_word == k0)
						begin
							locked_d = 1'b0;
							st_d     = KS_IDLE;
						end
						else
							st_d = (ctl_word == k1) ? KS_GOT1 : KS_IDLE;
					end
					default:
						st_d = KS_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_q       <= KS_IDLE;
			pend_q     <= 1'b0;
			cnt_q      <= '0;
			locked_q   <= 1'b0;
			lock_set_q <= 1'b0;
		end
		else
		begin
			st_q       <= st_d;
			pend_q     <= pend_d;
			cnt_q      <= cnt_d;
			locked_q   <= locked_d;
			lock_set_q <= lock_set_d;
		end
	end

endmodule : unlock_key_seq

// ### sim/host_model.sv
// host model driving the byte, word and key ports
`timescale 1ns/1ps
module host_model
	import gauge_blk_pkg::*;
(
	// clock and answer
	input  wire logic [7:0] cmd_rdata,
	input  wire logic       sys_clk,
	// requests
	output cmd_req_t        cmd_req,
	output logic [7:0]      std_rdata,
	output logic            ctl_wr,
	output logic [15:0]     ctl_word,
	output logic            key_wr,
	output logic [31:0]     key_wdata
);
	// measurement data seen by standard reads
	assign std_rdata = cmd_req.addr ^ 8'h5A;
	initial
	begin
		cmd_req = '0;
		ctl_wr = 1'b0;
		ctl_word = 16'h0000;
		key_wr = 1'b0;
		key_wdata = 32'h0;
	end
	task automatic op(input cmd_req_t r, output logic [7:0] d);
		@(negedge sys_clk);
		cmd_req = r;
		@(negedge sys_clk);
		d = cmd_rdata;
		cmd_req = {2'b00, ~r.addr, ~r.wdata};
		@(negedge sys_clk);
	endtask : op
	task automatic ctl(input logic [15:0] w);
		@(negedge sys_clk);
		ctl_wr = 1'b1;
		ctl_word = w;
		@(negedge sys_clk);
		ctl_wr = 1'b0;
		ctl_word = ~w;
		@(negedge sys_clk);
	endtask : ctl
	task automatic key(input logic [31:0] k);
		@(negedge sys_clk);
		key_wr = 1'b1;
		key_wdata = k;
		@(negedge sys_clk);
		key_wr = 1'b0;
		key_wdata = ~k;
	endtask : key
endmodule : host_model

// ### sim/gauge_blk_checker.sv
// port checker of the block data access and lock logic
`timescale 1ns/1ps
module gauge_blk_checker
	import gauge_blk_pkg::*;
#(
	parameter int LOCK_CYC = LOCK_CYC_DEF
)(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// observed ports
	input wire cmd_req_t    cmd_req,
	input wire logic [7:0]  std_rdata,
	input wire logic [7:0]  cmd_rdata,
	input wire logic        cmd_rvalid,
	input wire logic        ctl_wr,
	input wire logic [15:0] ctl_word,
	input wire logic        key_wr,
	input wire logic [31:0] key_wdata,
	input wire logic        locked_flag
);
	localparam int LK = LOCK_CYC + 2;
	logic [31:0] key_q;
	logic [31:0] key_d;
	logic [15:0] kw;
	assign kw = {key_q[23:16], key_q[31:24]};
	always_comb
	begin
		key_d = key_q;
		if (key_wr && !locked_flag)
			key_d = key_wdata;
	end
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			key_q <= KEY_DEFAULT;
		else
			key_q <= key_d;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_rd_answer: assert property (
		cmd_req.rd |=> cmd_rvalid) else $error("read not answered");
	chk_rvalid_cause: assert property (
		cmd_rvalid |-> $past(cmd_req.rd)) else $error("stray rvalid");
	chk_std_read: assert property (
		cmd_req.rd && cmd_req.addr <= STD_LAST
		|=> cmd_rdata == $past(std_rdata)) else $error("std read");
	chk_class_locked: assert property (
		locked_flag && cmd_req.rd && cmd_req.addr == CLASS_ADDR
		|=> cmd_rdata == 8'h00) else $error("class read locked");
	chk_acc_locked: assert property (
		locked_flag && cmd_req.rd && cmd_req.addr == ACC_ADDR
		|=> cmd_rdata == 8'h00) else $error("access read locked");
	chk_lock_delay: assert property (
		ctl_wr && ctl_word == LOCK_SUBCMD && !locked_flag
		|-> ##[1:LK] locked_flag) else $error("lock late");
	chk_unlock_key: assert property (
		$fell(locked_flag) |-> ($past(ctl_wr) && $past(ctl_word) == kw)
		|| ($past(ctl_wr, 2) && $past(ctl_word, 2) == kw))
		else $error("unlock without key");
	chk_lock_hold: assert property (
		locked_flag && !ctl_wr && !$past(ctl_wr) |=> locked_flag)
		else $error("lock dropped");
	cov_lock: cover property ($rose(locked_flag));
	cov_unlock: cover property ($fell(locked_flag));
	cov_sum: cover property (cmd_req.wr && cmd_req.addr == SUM_ADDR);
endmodule : gauge_blk_checker

// ### sim/tb_top.sv
// testbench of the block data access and lock logic
`timescale 1ns/1ps
module tb_top
	import gauge_blk_pkg::*;
;
	localparam int LOCK_CYC = 20;
	function automatic blk_t mk_rom();
		blk_t b;
		for (int i = 0; i < BLK_BYTES; i++)
			b[i] = 8'h10 + 8'(i);
		return b;
	endfunction : mk_rom
	localparam blk_t ROM = mk_rom();
	logic        sys_clk;
	logic        rst;
	cmd_req_t    cmd_req;
	logic [7:0]  std_rdata;
	logic [7:0]  cmd_rdata;
	logic        cmd_rvalid;
	logic        ctl_wr;
	logic [15:0] ctl_word;
	logic        key_wr;
	logic [31:0] key_wdata;
	logic        locked_flag;
	int          num_errors;
	int          samples_checked;
	gauge_block_data_access_lock #(.LOCK_CYC(LOCK_CYC), .ROM_BLK(ROM)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .cmd_req(cmd_req),
		.std_rdata(std_rdata), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid), .ctl_wr(ctl_wr), .ctl_word(ctl_word),
		.key_wr(key_wr), .key_wdata(key_wdata), .locked_flag(locked_flag));
	host_model u_host (
		.cmd_rdata(cmd_rdata), .sys_clk(sys_clk), .cmd_req(cmd_req),
		.std_rdata(std_rdata), .ctl_wr(ctl_wr), .ctl_word(ctl_word),
		.key_wr(key_wr), .key_wdata(key_wdata));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.op({2'b10, a, d}, x);
	endtask : wr
	task automatic rdb(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.op({2'b01, a, 8'h00}, d);
		chk($sformatf("byte %h", a), e, d);
	endtask : rdb
	task automatic sel(input logic [7:0] c, input logic [7:0] b);
		wr(CLASS_ADDR, c);
		wr(BLKIDX_ADDR, b);
		wr(ACC_ADDR, ACC_ENABLE);
	endtask : sel
	// writes v+i to n window bytes, gives the buffer checksum
	task automatic fill(input logic [7:0] v, input int n, output logic [7:0] s);
		logic [7:0] b [BLK_BYTES];
		s = SUM_BASE;
		for (int i = 0; i < n; i++)
		begin
			wr(WIN_BASE + 8'(i % 32), v + 8'(i));
			b[i % 32] = v + 8'(i);
		end
		foreach (b[i])
			s = s - b[i];
	endtask : fill
	task automatic t_rom();
		chk("locked", 8'h00, {7'h0, locked_flag});
		sel(8'h40, 8'h00);
		for (int i = 0; i < BLK_BYTES; i++)
			rdb(WIN_BASE + 8'(i), ROM[i]);
		$display("test rom done");
	endtask : t_rom
	task automatic t_commit();
		logic [7:0] s;
		sel(8'h40, 8'h00);
		fill(8'h80, 32, s);
		wr(SUM_ADDR, ~s);
		rdb(8'h45, 8'h85);
		rdb(SUM_ADDR, s);
		sel(8'h40, 8'h00);
		rdb(8'h45, ROM[5]);
		fill(8'h80, 32, s);
		wr(SUM_ADDR, s);
		sel(8'h40, 8'h00);
		rdb(8'h45, 8'h85);
		$display("test commit done");
	endtask : t_commit
	task automatic t_ovf();
		logic [7:0] s;
		sel(8'h01, 8'h01);
		fill(8'h20, 32, s);
		wr(SUM_ADDR, s);
		sel(8'h01, 8'h01);
		rdb(8'h42, 8'h22);
		fill(8'h50, 33, s);
		wr(SUM_ADDR, s);
		sel(8'h01, 8'h01);
		rdb(8'h42, 8'h22);
		$display("test overflow done");
	endtask : t_ovf
	task automatic t_persist();
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		sel(8'h01, 8'h01);
		rdb(8'h42, 8'h22);
		sel(8'h40, 8'h00);
		rdb(8'h45, ROM[5]);
		$display("test persist done");
	endtask : t_persist
	task automatic t_lock();
		logic [7:0] s;
		sel(MAKER_CLASS, 8'h00);
		fill(8'hC0, 32, s);
		wr(SUM_ADDR, s);
		u_host.ctl(LOCK_SUBCMD);
		repeat (LOCK_CYC + 2) @(negedge sys_clk);
		chk("locked", 8'h01, {7'h0, locked_flag});
		rdb(8'h10, 8'h10 ^ 8'h5A);
		rdb(CLASS_ADDR, 8'h00);
		rdb(ACC_ADDR, 8'h00);
		wr(BLKIDX_ADDR, MAKER_BLK);
		wr(8'h41, 8'hEE);
		wr(CLASS_ADDR, 8'h40);
		wr(ACC_ADDR, ACC_ENABLE);
		for (int i = 0; i < BLK_BYTES; i++)
			rdb(WIN_BASE + 8'(i), i < 8 ? 8'hC0 + 8'(i) : 8'h00);
		rdb(SUM_ADDR, SUM_BASE - 8'h1C);
		$display("test lock done");
	endtask : t_lock
	task automatic t_unlock();
		logic [15:0] lo;
		logic [15:0] hi;
		lo = {KEY_DEFAULT[7:0], KEY_DEFAULT[15:8]};
		hi = {KEY_DEFAULT[23:16], KEY_DEFAULT[31:24]};
		u_host.key(32'h1357_9BDF);
		u_host.ctl(lo);
		u_host.ctl(16'h0BAD);
		u_host.ctl(hi);
		chk("locked", 8'h01, {7'h0, locked_flag});
		u_host.ctl(lo);
		u_host.ctl(hi);
		chk("locked", 8'h00, {7'h0, locked_flag});
		chk("key lo", 8'h01, {7'h0, lo != LOCK_SUBCMD});
		rdb(CLASS_ADDR, MAKER_CLASS);
		rdb(ACC_ADDR, ACC_IDLE);
		$display("test unlock done");
	endtask : t_unlock
	task automatic t_rekey();
		u_host.key(32'h1357_9BDF);
		u_host.ctl(LOCK_SUBCMD);
		repeat (LOCK_CYC + 2) @(negedge sys_clk);
		u_host.ctl({KEY_DEFAULT[7:0], KEY_DEFAULT[15:8]});
		u_host.ctl({KEY_DEFAULT[23:16], KEY_DEFAULT[31:24]});
		chk("locked", 8'h01, {7'h0, locked_flag});
		u_host.ctl(16'hDF9B);
		u_host.ctl(16'h5713);
		chk("locked", 8'h00, {7'h0, locked_flag});
		$display("test rekey done");
	endtask : t_rekey
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		t_rom();
		t_commit();
		t_ovf();
		t_persist();
		t_lock();
		t_unlock();
		t_rekey();
		print_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		print_verdict();
	end
endmodule : tb_top
bind gauge_block_data_access_lock gauge_blk_checker #(.LOCK_CYC(LOCK_CYC)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .cmd_req(cmd_req), .std_rdata(std_rdata),
	.cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .ctl_wr(ctl_wr),
	.ctl_word(ctl_word), .key_wr(key_wr), .key_wdata(key_wdata),
	.locked_flag(locked_flag));
